/* port_mux_pkg.sv */
// How it works
// - Alternate mode hands pin to peripheral
// - Port0 pin0: timer6 capture1 or output1
// - Port0 pin1: timer6 capture0 or output0
// - Port0 pin2 alternate is non-maskable interrupt
// - Port0 pin3: ext_irq0 or A/D trigger
// - Port0 pins 4, 6: ext_irq1, ext_irq3
// - Port0 pin5 ext_irq2; debug override wins
// - Port1 pins 0, 1 carry D/A when input
// - Port3 pin0: uart0 transmit or csi4 out
// - Port3 pin1: uart0 rx+ext_irq7 or csi4 in
// - Port3 pin2 two-bit selector, four functions
// - Port3 pin3: timer0 capture1 or output1
// - Port3 pin4: timer1 capture0 or output0
// - Port3 pin5: timer1 capture1 or output1
// - Port3 pin8: uart2 transmit or two-wire0 data
// - Port3 pin9: uart2 receive or two-wire0 clock
// - Port4 pin0: csi0 in or two-wire1 data
package port_mux_pkg;
  localparam int PIN_COUNT = 20;
  localparam int PORT_COUNT = 4;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;

  // Flat pad index of each port's pin 0
  localparam int P0_BASE = 0;
  localparam int P1_BASE = 7;
  localparam int P3_BASE = 9;
  localparam int P4_BASE = 19;

  // Register bank index of each port
  localparam int PX_P0 = 0;
  localparam int PX_P1 = 1;
  localparam int PX_P3 = 2;
  localparam int PX_P4 = 3;

  // Byte address: upper nibble picks port bank, lower nibble the register
  localparam logic [3:0] SLOT_LATCH = 4'h0;
  localparam logic [3:0] SLOT_DIR = 4'h2;
  localparam logic [3:0] SLOT_MODE = 4'h4;
  localparam logic [3:0] SLOT_FSEL_LOW = 4'h6;
  localparam logic [3:0] SLOT_FSEL_HIGH = 4'h8;
  localparam logic [3:0] SLOT_LEVEL = 4'hA;
  localparam logic [ADDR_W-1:0] ADDR_DEBUG_CTRL = 8'h40;
  localparam int DEBUG_OVERRIDE_BIT = 0;

  localparam logic [DATA_W-1:0] LATCH_RST = 16'h0000;
  localparam logic [DATA_W-1:0] DIR_RST = 16'hFFFF;
  localparam logic [DATA_W-1:0] MODE_RST = 16'h0000;
  localparam logic [DATA_W-1:0] FSEL_RST = 16'h0000;

  // Implemented pins per bank: port0 7, port1 2, port3 10, port4 1
  localparam logic [PORT_COUNT-1:0][DATA_W-1:0] PORT_MASK =
    {16'h0001, 16'h03FF, 16'h0003, 16'h007F};

  // Two-bit selector codes {func_sel_high, func_sel_low}
  localparam logic [1:0] SEL_BAUD_CLK = 2'h0;
  localparam logic [1:0] SEL_CSI_CLK = 2'h1;
  localparam logic [1:0] SEL_CAPTURE = 2'h2;
  localparam logic [1:0] SEL_TIMER_OUT = 2'h3;

  typedef struct packed {
    logic timer6_out0;
    logic timer6_out1;
    logic uart0_tx;
    logic csi4_serial_out;
    logic csi4_clk_out;
    logic csi4_clk_oe;
    logic timer0_out0;
    logic timer0_out1;
    logic timer1_out0;
    logic timer1_out1;
    logic uart2_tx;
    logic twowire0_data_low;
    logic twowire0_clock_low;
    logic twowire1_data_low;
  } periph_out_t;

  typedef struct packed {
    logic timer6_capture_in0;
    logic timer6_capture_in1;
    logic nmi_in;
    logic ext_irq0;
    logic ext_irq1;
    logic ext_irq2;
    logic ext_irq3;
    logic ext_irq7;
    logic adc_ext_trigger;
    logic debug_reset_in;
    logic uart0_rx;
    logic uart0_baud_clk_in;
    logic csi4_serial_in;
    logic csi4_clk_in;
    logic timer0_capture_in0;
    logic timer0_capture_in1;
    logic timer1_capture_in0;
    logic timer1_capture_in1;
    logic uart2_rx;
    logic twowire0_data_in;
    logic twowire0_clock_in;
    logic twowire1_data_in;
    logic csi0_serial_in;
  } periph_in_t;

  // Unselected UART receive and two-wire lines idle high, everything else low
  localparam periph_in_t PERIPH_IN_IDLE = '{uart0_rx: 1'h1, uart2_rx: 1'h1,
    twowire0_data_in: 1'h1, twowire0_clock_in: 1'h1, twowire1_data_in: 1'h1,
    default: 1'h0};
endpackage : port_mux_pkg

/* pin_cell.sv */
module pin_cell (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Port bits
  input wire logic alt_mode,
  input wire logic dir,
  input wire logic latch,
  // Peripheral drive
  input wire logic alt_out,
  input wire logic alt_oe,
  // Pad
  output logic pad_out,
  output logic pad_oe
);
  logic next_out;
  logic next_oe;

  // Alternate mode ignores latch and direction
  always_comb begin
    if (alt_mode) begin
      next_out = alt_out;
      next_oe = alt_oe;
    end else begin
      next_out = latch;
      next_oe = ~dir;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pad_out <= 1'h0;
      pad_oe <= 1'h0;
    end else begin
      pad_out <= next_out;
      pad_oe <= next_oe;
    end
  end
endmodule : pin_cell

/* port_alt_function_mux.sv */
// Design decisions made here: the address-and-strobe port and the register addresses.
module port_alt_function_mux (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Register port
  input wire logic [port_mux_pkg::ADDR_W-1:0] addr,
  input wire logic [port_mux_pkg::DATA_W-1:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [port_mux_pkg::DATA_W-1:0] rdata,
  // Pads
  input wire logic [port_mux_pkg::PIN_COUNT-1:0] pad_in,
  output logic [port_mux_pkg::PIN_COUNT-1:0] pad_out,
  output logic [port_mux_pkg::PIN_COUNT-1:0] pad_oe,
  // D/A switch for port1 pins 0 and 1
  output logic [1:0] dac_connect,
  // Peripherals
  input wire port_mux_pkg::periph_out_t periph_out,
  output port_mux_pkg::periph_in_t periph_in
);
  import port_mux_pkg::*;

  logic [PORT_COUNT-1:0][DATA_W-1:0] latch_r;
  logic [PORT_COUNT-1:0][DATA_W-1:0] dir_r;
  logic [PORT_COUNT-1:0][DATA_W-1:0] mode_r;
  logic [PORT_COUNT-1:0][DATA_W-1:0] fsel_low;
  logic [PORT_COUNT-1:0][DATA_W-1:0] fsel_high;
  logic [PORT_COUNT-1:0][DATA_W-1:0] level;
  logic debug_pin_override;
  logic [DATA_W-1:0] next_rdata;
  logic [PIN_COUNT-1:0] alt_mode;
  logic [PIN_COUNT-1:0] alt_out;
  logic [PIN_COUNT-1:0] alt_oe;
  logic [PIN_COUNT-1:0] dir_flat;
  logic [PIN_COUNT-1:0] latch_flat;
  logic [1:0] p32_sel;
  periph_in_t next_in;

  assign level[PX_P0] = {9'h000, pad_in[P1_BASE-1:P0_BASE]};
  assign level[PX_P1] = {14'h0000, pad_in[P3_BASE-1:P1_BASE]};
  assign level[PX_P3] = {6'h00, pad_in[P4_BASE-1:P3_BASE]};
  assign level[PX_P4] = {15'h0000, pad_in[P4_BASE]};

  assign dir_flat = {dir_r[PX_P4][0], dir_r[PX_P3][9:0], dir_r[PX_P1][1:0],
    dir_r[PX_P0][6:0]};
  assign latch_flat = {latch_r[PX_P4][0], latch_r[PX_P3][9:0], latch_r[PX_P1][1:0],
    latch_r[PX_P0][6:0]};
  assign p32_sel = {fsel_high[PX_P3][2], fsel_low[PX_P3][2]};

  // Port register banks
  for (genvar p = 0; p < PORT_COUNT; p++) begin : g_bank
    always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
        latch_r[p] <= LATCH_RST;
        dir_r[p] <= DIR_RST & PORT_MASK[p];
        mode_r[p] <= MODE_RST;
        fsel_low[p] <= FSEL_RST;
        fsel_high[p] <= FSEL_RST;
      end else if (wr_stb && int'(addr[7:4]) == p) begin
        if (addr[3:0] == SLOT_LATCH) begin
          latch_r[p] <= wdata & PORT_MASK[p];
        end else if (addr[3:0] == SLOT_DIR) begin
          dir_r[p] <= wdata & PORT_MASK[p];
        end else if (addr[3:0] == SLOT_MODE) begin
          mode_r[p] <= wdata & PORT_MASK[p];
        end else if (addr[3:0] == SLOT_FSEL_LOW) begin
          fsel_low[p] <= wdata & PORT_MASK[p];
        end else if (addr[3:0] == SLOT_FSEL_HIGH) begin
          fsel_high[p] <= wdata & PORT_MASK[p];
        end
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      debug_pin_override <= 1'h0;
    end else if (wr_stb && addr == ADDR_DEBUG_CTRL) begin
      debug_pin_override <= wdata[DEBUG_OVERRIDE_BIT];
    end
  end

  // Read data valid only in the cycle after the strobe
  always_comb begin
    next_rdata = '0;
    if (rd_stb) begin
      if (addr == ADDR_DEBUG_CTRL) begin
        next_rdata[DEBUG_OVERRIDE_BIT] = debug_pin_override;
      end else if (addr[7:4] < 4'h4) begin
        if (addr[3:0] == SLOT_LATCH) begin
          next_rdata = latch_r[addr[5:4]];
        end else if (addr[3:0] == SLOT_DIR) begin
          next_rdata = dir_r[addr[5:4]];
        end else if (addr[3:0] == SLOT_MODE) begin
          next_rdata = mode_r[addr[5:4]];
        end else if (addr[3:0] == SLOT_FSEL_LOW) begin
          next_rdata = fsel_low[addr[5:4]];
        end else if (addr[3:0] == SLOT_FSEL_HIGH) begin
          next_rdata = fsel_high[addr[5:4]];
        end else if (addr[3:0] == SLOT_LEVEL) begin
          next_rdata = level[addr[5:4]];
        end
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rdata <= '0;
    end else begin
      rdata <= next_rdata;
    end
  end

  // Function routing
  always_comb begin
    next_in = PERIPH_IN_IDLE;
    alt_out = '0;
    alt_oe = '0;
    alt_mode = '0;
    alt_mode[P1_BASE-1:P0_BASE] = mode_r[PX_P0][6:0];
    alt_mode[P3_BASE+5:P3_BASE] = mode_r[PX_P3][5:0];
    alt_mode[P3_BASE+9:P3_BASE+8] = mode_r[PX_P3][9:8];
    alt_mode[P4_BASE] = mode_r[PX_P4][0];
    if (mode_r[PX_P0][0]) begin
      if (fsel_low[PX_P0][0]) begin
        alt_out[P0_BASE] = periph_out.timer6_out1;
        alt_oe[P0_BASE] = 1'h1;
      end else begin
        next_in.timer6_capture_in1 = pad_in[P0_BASE];
      end
    end
    if (mode_r[PX_P0][1]) begin
      if (fsel_low[PX_P0][1]) begin
        alt_out[P0_BASE+1] = periph_out.timer6_out0;
        alt_oe[P0_BASE+1] = 1'h1;
      end else begin
        next_in.timer6_capture_in0 = pad_in[P0_BASE+1];
      end
    end
    if (mode_r[PX_P0][2]) begin
      next_in.nmi_in = pad_in[P0_BASE+2];
    end
    if (mode_r[PX_P0][3]) begin
      if (fsel_low[PX_P0][3]) begin
        next_in.adc_ext_trigger = pad_in[P0_BASE+3];
      end else begin
        next_in.ext_irq0 = pad_in[P0_BASE+3];
      end
    end
    if (mode_r[PX_P0][4]) begin
      next_in.ext_irq1 = pad_in[P0_BASE+4];
    end
    if (mode_r[PX_P0][6]) begin
      next_in.ext_irq3 = pad_in[P0_BASE+6];
    end
    if (debug_pin_override) begin
      alt_mode[P0_BASE+5] = 1'h1;
      next_in.debug_reset_in = pad_in[P0_BASE+5];
    end else if (mode_r[PX_P0][5]) begin
      next_in.ext_irq2 = pad_in[P0_BASE+5];
    end
    if (mode_r[PX_P3][0]) begin
      alt_oe[P3_BASE] = 1'h1;
      alt_out[P3_BASE] = fsel_low[PX_P3][0] ? periph_out.csi4_serial_out
                                            : periph_out.uart0_tx;
    end
    if (mode_r[PX_P3][1]) begin
      if (fsel_low[PX_P3][1]) begin
        next_in.csi4_serial_in = pad_in[P3_BASE+1];
      end else begin
        next_in.uart0_rx = pad_in[P3_BASE+1];
        next_in.ext_irq7 = pad_in[P3_BASE+1];
      end
    end
    if (mode_r[PX_P3][2]) begin
      case (p32_sel)
        SEL_BAUD_CLK: next_in.uart0_baud_clk_in = pad_in[P3_BASE+2];
        SEL_CSI_CLK: begin
          next_in.csi4_clk_in = pad_in[P3_BASE+2];
          alt_out[P3_BASE+2] = periph_out.csi4_clk_out;
          alt_oe[P3_BASE+2] = periph_out.csi4_clk_oe;
        end
        SEL_CAPTURE: next_in.timer0_capture_in0 = pad_in[P3_BASE+2];
        SEL_TIMER_OUT: begin
          alt_out[P3_BASE+2] = periph_out.timer0_out0;
          alt_oe[P3_BASE+2] = 1'h1;
        end
        default: next_in.uart0_baud_clk_in = pad_in[P3_BASE+2];
      endcase
    end
    if (mode_r[PX_P3][3]) begin
      if (fsel_low[PX_P3][3]) begin
        alt_out[P3_BASE+3] = periph_out.timer0_out1;
        alt_oe[P3_BASE+3] = 1'h1;
      end else begin
        next_in.timer0_capture_in1 = pad_in[P3_BASE+3];
      end
    end
    if (mode_r[PX_P3][4]) begin
      if (fsel_low[PX_P3][4]) begin
        alt_out[P3_BASE+4] = periph_out.timer1_out0;
        alt_oe[P3_BASE+4] = 1'h1;
      end else begin
        next_in.timer1_capture_in0 = pad_in[P3_BASE+4];
      end
    end
    if (mode_r[PX_P3][5]) begin
      if (fsel_low[PX_P3][5]) begin
        alt_out[P3_BASE+5] = periph_out.timer1_out1;
        alt_oe[P3_BASE+5] = 1'h1;
      end else begin
        next_in.timer1_capture_in1 = pad_in[P3_BASE+5];
      end
    end
    // Two-wire lines are open drain: drive low only
    if (mode_r[PX_P3][8]) begin
      if (fsel_low[PX_P3][8]) begin
        alt_oe[P3_BASE+8] = periph_out.twowire0_data_low;
        next_in.twowire0_data_in = pad_in[P3_BASE+8];
      end else begin
        alt_out[P3_BASE+8] = periph_out.uart2_tx;
        alt_oe[P3_BASE+8] = 1'h1;
      end
    end
    if (mode_r[PX_P3][9]) begin
      if (fsel_low[PX_P3][9]) begin
        alt_oe[P3_BASE+9] = periph_out.twowire0_clock_low;
        next_in.twowire0_clock_in = pad_in[P3_BASE+9];
      end else begin
        next_in.uart2_rx = pad_in[P3_BASE+9];
      end
    end
    if (mode_r[PX_P4][0]) begin
      if (fsel_low[PX_P4][0]) begin
        alt_oe[P4_BASE] = periph_out.twowire1_data_low;
        next_in.twowire1_data_in = pad_in[P4_BASE];
      end else begin
        next_in.csi0_serial_in = pad_in[P4_BASE];
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      periph_in <= PERIPH_IN_IDLE;
      dac_connect <= 2'h0;
    end else begin
      periph_in <= next_in;
      dac_connect <= dir_r[PX_P1][1:0];
    end
  end

  for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
    pin_cell u_cell (
      .clock(clock),
      .nrst(nrst),
      .alt_mode(alt_mode[i]),
      .dir(dir_flat[i]),
      .latch(latch_flat[i]),
      .alt_out(alt_out[i]),
      .alt_oe(alt_oe[i]),
      .pad_out(pad_out[i]),
      .pad_oe(pad_oe[i])
    );
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  chk_general_port_pin: assert property (
    !mode_r[PX_P0][3] |=> pad_out[P0_BASE+3] == $past(latch_r[PX_P0][3])
      && pad_oe[P0_BASE+3] == !$past(dir_r[PX_P0][3]))
    else $error("general port pin does not follow latch and direction");
  chk_alt_ignores_latch: assert property (
    mode_r[PX_P0][0] && fsel_low[PX_P0][0] |=> pad_oe[P0_BASE]
      && pad_out[P0_BASE] == $past(periph_out.timer6_out1))
    else $error("alternate pin not driven by timer output");
  chk_timer6_capture: assert property (
    mode_r[PX_P0][1] && !fsel_low[PX_P0][1] |=> !pad_oe[P0_BASE+1]
      && periph_in.timer6_capture_in0 == $past(pad_in[P0_BASE+1]))
    else $error("timer capture input not routed");
  chk_nmi_route: assert property (
    mode_r[PX_P0][2] |=> periph_in.nmi_in == $past(pad_in[P0_BASE+2]))
    else $error("interrupt pin not routed");
  chk_adc_trigger: assert property (
    mode_r[PX_P0][3] && fsel_low[PX_P0][3] |=> !periph_in.ext_irq0
      && periph_in.adc_ext_trigger == $past(pad_in[P0_BASE+3]))
    else $error("trigger selection wrong");
  chk_irq3_route: assert property (
    mode_r[PX_P0][6] |=> periph_in.ext_irq3 == $past(pad_in[P0_BASE+6]))
    else $error("ext_irq3 not routed");
  chk_debug_override: assert property (
    debug_pin_override |=> !pad_oe[P0_BASE+5] && !periph_in.ext_irq2
      && periph_in.debug_reset_in == $past(pad_in[P0_BASE+5]))
    else $error("debug override not taking pin");
  chk_dac_switch: assert property (
    nrst |=> dac_connect == $past(dir_r[PX_P1][1:0])
      && (dac_connect & pad_oe[P1_BASE+1:P1_BASE]) == 2'h0)
    else $error("D/A switch does not follow direction");
  chk_uart0_tx: assert property (
    mode_r[PX_P3][0] && !fsel_low[PX_P3][0] |=> pad_oe[P3_BASE]
      && pad_out[P3_BASE] == $past(periph_out.uart0_tx))
    else $error("uart0 transmit not on pin");
  chk_shared_receive: assert property (
    mode_r[PX_P3][1] && !fsel_low[PX_P3][1] |=>
      periph_in.uart0_rx == periph_in.ext_irq7 && !periph_in.csi4_serial_in)
    else $error("shared receive pin not fanned out");
  chk_sel_timer_out: assert property (
    mode_r[PX_P3][2] && p32_sel == SEL_TIMER_OUT |=> pad_oe[P3_BASE+2]
      && pad_out[P3_BASE+2] == $past(periph_out.timer0_out0))
    else $error("two-bit selector output wrong");
  chk_timer0_out1: assert property (
    mode_r[PX_P3][3] && fsel_low[PX_P3][3] |=> pad_oe[P3_BASE+3])
    else $error("timer0 output not enabled");
  chk_timer1_out0: assert property (
    mode_r[PX_P3][4] && fsel_low[PX_P3][4] |=>
      pad_out[P3_BASE+4] == $past(periph_out.timer1_out0))
    else $error("timer1 output0 not on pin");
  chk_timer1_capture: assert property (
    mode_r[PX_P3][5] && !fsel_low[PX_P3][5] |=> !pad_oe[P3_BASE+5])
    else $error("capture pin driven");
  chk_twowire_drain: assert property (
    mode_r[PX_P3][8] && fsel_low[PX_P3][8] |=> !pad_out[P3_BASE+8]
      && pad_oe[P3_BASE+8] == $past(periph_out.twowire0_data_low))
    else $error("two-wire data not open drain");
  chk_uart2_rx: assert property (
    mode_r[PX_P3][9] && !fsel_low[PX_P3][9] |=>
      periph_in.uart2_rx == $past(pad_in[P3_BASE+9]) && !pad_oe[P3_BASE+9])
    else $error("uart2 receive not routed");
  chk_csi0_in: assert property (
    mode_r[PX_P4][0] && !fsel_low[PX_P4][0] |=>
      periph_in.csi0_serial_in == $past(pad_in[P4_BASE]))
    else $error("csi0 input not routed");

  cov_csi_clock: cover property (mode_r[PX_P3][2] && p32_sel == SEL_CSI_CLK);
  cov_debug: cover property (debug_pin_override && mode_r[PX_P0][5]);
  cov_twowire: cover property (mode_r[PX_P4][0] && fsel_low[PX_P4][0]);
  cov_read: cover property (wr_stb ##1 rd_stb);
endmodule : port_alt_function_mux

/* pad_world.sv */
module pad_world (
  // Design pads
  input wire logic [port_mux_pkg::PIN_COUNT-1:0] pad_out,
  input wire logic [port_mux_pkg::PIN_COUNT-1:0] pad_oe,
  // Board drivers
  input wire logic [port_mux_pkg::PIN_COUNT-1:0] ext_val,
  input wire logic [port_mux_pkg::PIN_COUNT-1:0] ext_en,
  // Resolved level
  output logic [port_mux_pkg::PIN_COUNT-1:0] pad_in
);
  timeunit 1ns;
  timeprecision 100ps;
  import port_mux_pkg::*;
  // Device drive wins, then board driver, else board pull-up
  always_comb begin
    for (int i = 0; i < PIN_COUNT; i++) begin
      pad_in[i] = pad_oe[i] ? pad_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
    end
  end
endmodule : pad_world

/* port_alt_function_mux_tb.sv */
module port_alt_function_mux_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import port_mux_pkg::*;
  logic clock;
  logic nrst;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic wr_stb;
  logic rd_stb;
  logic [DATA_W-1:0] rdata;
  logic [PIN_COUNT-1:0] pad_in, pad_out, pad_oe, ext_val, ext_en;
  logic [1:0] dac_connect;
  periph_out_t periph_out;
  periph_in_t periph_in;
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;
  int base[4] = '{P0_BASE, P1_BASE, P3_BASE, P4_BASE};

  port_alt_function_mux u_dut (.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe(pad_oe), .dac_connect(dac_connect), .periph_out(periph_out),
    .periph_in(periph_in));
  pad_world u_pads (.pad_out(pad_out), .pad_oe(pad_oe), .ext_val(ext_val),
    .ext_en(ext_en), .pad_in(pad_in));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  always @(posedge clock) begin
    cycles++;
    if (cycles == 8000) begin
      $display("[FAIL] run time limit reached");
      fail_count++;
      finish_test();
    end
  end

  task automatic check(string name, logic [31:0] got, logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic wr(logic [7:0] a, logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
  endtask : wr

  task automatic rd(logic [7:0] a, logic [15:0] exp);
    @(posedge clock);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    #1;
    check($sformatf("read %h", a), 32'(rdata), 32'(exp));
  endtask : rd

  task automatic settle();
    repeat (3) @(posedge clock);
    #1;
  endtask : settle

  task automatic cfg(int bank, int pin, logic fl, logic fh);
    wr({4'(bank), SLOT_MODE}, 16'h0001 << pin);
    wr({4'(bank), SLOT_FSEL_LOW}, 16'(fl) << pin);
    wr({4'(bank), SLOT_FSEL_HIGH}, 16'(fh) << pin);
  endtask : cfg

  // Output function: pad follows the peripheral, not the latch of ones
  task automatic out_case(int bank, int pin, logic fl, logic fh, periph_out_t po);
    int i;
    i = base[bank] + pin;
    cfg(bank, pin, fl, fh);
    periph_out <= po;
    settle();
    check($sformatf("pad %0d high", i), 32'(pad_out[i]), 32'h0000_0001);
    check($sformatf("pad %0d oe", i), 32'(pad_oe[i]), 32'h0000_0001);
    @(posedge clock);
    periph_out <= '0;
    settle();
    check($sformatf("pad %0d low", i), 32'(pad_out[i]), 32'h0000_0000);
  endtask : out_case

  // Input function: pad undriven despite output direction, level reaches peripheral
  task automatic in_case(int bank, int pin, logic fl, logic fh, periph_in_t m);
    int i;
    i = base[bank] + pin;
    cfg(bank, pin, fl, fh);
    for (int v = 0; v < 2; v++) begin
      @(posedge clock);
      ext_val[i] <= v[0];
      settle();
      check($sformatf("pad %0d in", i), 32'(periph_in & m), v ? 32'(m) : 32'h0000_0000);
    end
    check($sformatf("pad %0d oe", i), 32'(pad_oe[i]), 32'h0000_0000);
  endtask : in_case

  // Two-wire line: pulls low only, reads the resolved level back
  task automatic od_case(int bank, int pin, periph_out_t po, periph_in_t m);
    int i;
    i = base[bank] + pin;
    cfg(bank, pin, 1'b1, 1'b0);
    ext_en[i] <= 1'b0;
    periph_out <= po;
    settle();
    check($sformatf("od %0d oe", i), 32'(pad_oe[i]), 32'h0000_0001);
    check($sformatf("od %0d out", i), 32'(pad_out[i]), 32'h0000_0000);
    check($sformatf("od %0d low", i), 32'(periph_in & m), 32'h0000_0000);
    @(posedge clock);
    periph_out <= '0;
    settle();
    check($sformatf("od %0d rel", i), 32'(pad_oe[i]), 32'h0000_0000);
    check($sformatf("od %0d high", i), 32'(periph_in & m), 32'(m));
    @(posedge clock);
    ext_en[i] <= 1'b1;
  endtask : od_case

  task automatic reset_test();
    settle();
    check("oe after reset", 32'(pad_oe), 32'h0000_0000);
    check("periph idle", 32'(periph_in), 32'(PERIPH_IN_IDLE));
    check("dac after reset", 32'(dac_connect), 32'h0000_0003);
    rd(8'h02, 16'h007F);
    rd(8'h22, 16'h03FF);
    rd(8'h24, 16'h0000);
    rd(8'h00, 16'h0000);
    rd(8'h40, 16'h0000);
    rd(8'h50, 16'h0000);
  endtask : reset_test

  task automatic gp_test();
    wr(8'h00, 16'h0055);
    wr(8'h02, 16'h0000);
    wr(8'h06, 16'h007F);
    wr(8'h08, 16'h007F);
    settle();
    check("gp out", 32'(pad_out[6:0]), 32'h0000_0055);
    check("gp oe", 32'(pad_oe[6:0]), 32'h0000_007F);
    rd(8'h0A, 16'h0055);
    wr(8'h00, 16'hFFFF);
    wr(8'h20, 16'hFFFF);
    wr(8'h22, 16'h0000);
    wr(8'h30, 16'hFFFF);
    wr(8'h32, 16'h0000);
    settle();
    check("gp out hi", 32'(pad_out[19:9]), 32'h0000_07FF);
    check("gp oe hi", 32'(pad_oe[19:9]), 32'h0000_07FF);
  endtask : gp_test

  task automatic debug_test();
    // Pin 5 left as a driven general port with latch low
    wr(8'h00, 16'h005F);
    wr(8'h04, 16'h0000);
    wr(8'h40, 16'h0001);
    ext_val[5] <= 1'b1;
    settle();
    check("dbg oe", 32'(pad_oe[5]), 32'h0000_0000);
    check("dbg in", 32'(periph_in.debug_reset_in), 32'h0000_0001);
    check("dbg irq2", 32'(periph_in.ext_irq2), 32'h0000_0000);
    wr(8'h40, 16'h0000);
    in_case(0, 5, 1'b0, 1'b0, '{ext_irq2: 1'h1, default: 1'h0});
  endtask : debug_test

  task automatic dac_test();
    for (int v = 0; v < 4; v++) begin
      wr(8'h12, 16'(v));
      settle();
      check("dac connect", 32'(dac_connect), 32'(v));
    end
  endtask : dac_test

  initial begin
    nrst = 1'b0;
    addr = '0;
    wdata = '0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    ext_val = '0;
    ext_en = '1;
    periph_out = '0;
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    reset_test();
    gp_test();
    out_case(0, 0, 1'b1, 1'b0, '{timer6_out1: 1'h1, default: 1'h0});
    in_case(0, 0, 1'b0, 1'b0, '{timer6_capture_in1: 1'h1, default: 1'h0});
    out_case(0, 1, 1'b1, 1'b0, '{timer6_out0: 1'h1, default: 1'h0});
    in_case(0, 1, 1'b0, 1'b0, '{timer6_capture_in0: 1'h1, default: 1'h0});
    in_case(0, 2, 1'b0, 1'b0, '{nmi_in: 1'h1, default: 1'h0});
    in_case(0, 3, 1'b0, 1'b0, '{ext_irq0: 1'h1, default: 1'h0});
    in_case(0, 3, 1'b1, 1'b0, '{adc_ext_trigger: 1'h1, default: 1'h0});
    in_case(0, 4, 1'b0, 1'b0, '{ext_irq1: 1'h1, default: 1'h0});
    in_case(0, 6, 1'b0, 1'b0, '{ext_irq3: 1'h1, default: 1'h0});
    debug_test();
    dac_test();
    out_case(2, 0, 1'b0, 1'b0, '{uart0_tx: 1'h1, default: 1'h0});
    out_case(2, 0, 1'b1, 1'b0, '{csi4_serial_out: 1'h1, default: 1'h0});
    in_case(2, 1, 1'b0, 1'b0, '{uart0_rx: 1'h1, ext_irq7: 1'h1, default: 1'h0});
    in_case(2, 1, 1'b1, 1'b0, '{csi4_serial_in: 1'h1, default: 1'h0});
    in_case(2, 2, 1'b0, 1'b0, '{uart0_baud_clk_in: 1'h1, default: 1'h0});
    out_case(2, 2, 1'b1, 1'b0, '{csi4_clk_out: 1'h1, csi4_clk_oe: 1'h1, default: 1'h0});
    in_case(2, 2, 1'b1, 1'b0, '{csi4_clk_in: 1'h1, default: 1'h0});
    in_case(2, 2, 1'b0, 1'b1, '{timer0_capture_in0: 1'h1, default: 1'h0});
    out_case(2, 2, 1'b1, 1'b1, '{timer0_out0: 1'h1, default: 1'h0});
    out_case(2, 3, 1'b1, 1'b0, '{timer0_out1: 1'h1, default: 1'h0});
    in_case(2, 3, 1'b0, 1'b0, '{timer0_capture_in1: 1'h1, default: 1'h0});
    out_case(2, 4, 1'b1, 1'b0, '{timer1_out0: 1'h1, default: 1'h0});
    in_case(2, 4, 1'b0, 1'b0, '{timer1_capture_in0: 1'h1, default: 1'h0});
    out_case(2, 5, 1'b1, 1'b0, '{timer1_out1: 1'h1, default: 1'h0});
    in_case(2, 5, 1'b0, 1'b0, '{timer1_capture_in1: 1'h1, default: 1'h0});
    out_case(2, 8, 1'b0, 1'b0, '{uart2_tx: 1'h1, default: 1'h0});
    od_case(2, 8, '{twowire0_data_low: 1'h1, default: 1'h0}, '{twowire0_data_in: 1'h1, default: 1'h0});
    in_case(2, 9, 1'b0, 1'b0, '{uart2_rx: 1'h1, default: 1'h0});
    od_case(2, 9, '{twowire0_clock_low: 1'h1, default: 1'h0}, '{twowire0_clock_in: 1'h1, default: 1'h0});
    in_case(3, 0, 1'b0, 1'b0, '{csi0_serial_in: 1'h1, default: 1'h0});
    od_case(3, 0, '{twowire1_data_low: 1'h1, default: 1'h0}, '{twowire1_data_in: 1'h1, default: 1'h0});
    finish_test();
  end
endmodule : port_alt_function_mux_tb
